/* File: test/tb_top.sv */
/*
 * Self-checking bench for bidl_core: literal, inc/dec and skip ops.
 * Assumes results appear one cycle after the issuing edge.
 */
`timescale 1ns/10ps
`include "bidl_consts.svh"
module tb_top import bidl_pkg::*;;
    logic sys_clk, nrst, issue_en, dest_sel, file_we, zero_flag, skip_next;
    bidl_op_type op;
    logic [6:0] file_addr, file_waddr;
    logic [7:0] literal, file_rdata, file_wdata, accum;
    int bad_count = 0;
    int tests_run = 0;

    bidl_core bidl_core_i (.sys_clk(sys_clk), .nrst(nrst), .issue_en(issue_en), .op(op),
        .dest_sel(dest_sel), .file_addr(file_addr), .literal(literal),
        .file_rdata(file_rdata), .file_we(file_we), .file_waddr(file_waddr),
        .file_wdata(file_wdata), .accum(accum), .zero_flag(zero_flag), .skip_next(skip_next));

    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic outs(input logic [7:0] a, input logic z, input logic we, input logic sk);
        chk({accum, zero_flag, file_we, skip_next}, {a, z, we, sk});
    endtask : outs

    // one issue pulse, then look one cycle later; read data is scrambled after use
    task automatic run(input bidl_op_type o, input logic d, input logic [7:0] lit,
        input logic [7:0] rd);
        @(posedge sys_clk);
        issue_en <= 1'b1;
        op <= o;
        dest_sel <= d;
        literal <= lit;
        file_rdata <= rd;
        @(posedge sys_clk);
        issue_en <= 1'b0;
        op <= BIDL_OP_NONE;
        file_rdata <= ~rd;
        literal <= ~lit;
        #1;
    endtask : run

    task automatic t_literal_ops;
        run(BIDL_OP_LOAD_LITERAL_ACCUM, 1'b0, 8'h00, 8'h00);
        outs(8'h00, 1'b0, 1'b0, 1'b0);
        run(BIDL_OP_OR_LITERAL_ACCUM, 1'b1, 8'h00, 8'h00);
        outs(8'h00, 1'b1, 1'b0, 1'b0);
        run(BIDL_OP_LOAD_LITERAL_ACCUM, 1'b0, 8'h30, 8'h00);
        outs(8'h30, 1'b1, 1'b0, 1'b0);
        run(BIDL_OP_OR_LITERAL_ACCUM, 1'b0, 8'h85, 8'h00);
        outs(8'hb5, 1'b0, 1'b0, 1'b0);
    endtask : t_literal_ops

    task automatic t_inc_dec;
        run(BIDL_OP_DECREMENT_FILE, 1'b0, 8'h00, 8'h00);
        outs(8'hff, 1'b0, 1'b0, 1'b0);
        run(BIDL_OP_INCREMENT_FILE, 1'b1, 8'h00, 8'hff);
        outs(8'hff, 1'b1, 1'b1, 1'b0);
        chk({file_waddr, file_wdata}, {7'h2a, 8'h00});
        run(BIDL_OP_DECREMENT_FILE, 1'b1, 8'h00, 8'h01);
        chk({file_we, zero_flag, file_wdata}, {2'b11, 8'h00});
        run(BIDL_OP_INCREMENT_FILE, 1'b0, 8'h00, 8'h41);
        outs(8'h42, 1'b0, 1'b0, 1'b0);
        run(BIDL_OP_NONE, 1'b1, 8'h00, 8'h00);
        outs(8'h42, 1'b0, 1'b0, 1'b0);
    endtask : t_inc_dec

    task automatic t_skip_ops;
        run(BIDL_OP_INCREMENT_SKIP_ZERO, 1'b1, 8'h00, 8'hff);
        outs(8'h42, 1'b0, 1'b1, 1'b1);
        chk(file_wdata, 8'h00);
        @(posedge sys_clk);
        #1;
        chk({file_we, skip_next}, 2'b00);
        run(BIDL_OP_DECREMENT_SKIP_ZERO, 1'b1, 8'h00, 8'h05);
        outs(8'h42, 1'b0, 1'b1, 1'b0);
        chk(file_wdata, 8'h04);
        run(BIDL_OP_INCREMENT_SKIP_ZERO, 1'b0, 8'h00, 8'h7f);
        outs(8'h80, 1'b0, 1'b0, 1'b0);
        // force zero high so a skip op that touched it would show
        run(BIDL_OP_LOAD_LITERAL_ACCUM, 1'b0, 8'h00, 8'h00);
        run(BIDL_OP_OR_LITERAL_ACCUM, 1'b0, 8'h00, 8'h00);
        run(BIDL_OP_DECREMENT_SKIP_ZERO, 1'b0, 8'h00, 8'h01);
        outs(8'h00, 1'b1, 1'b0, 1'b1);
        run(BIDL_OP_INCREMENT_SKIP_ZERO, 1'b0, 8'h00, 8'h02);
        outs(8'h03, 1'b1, 1'b0, 1'b0);
    endtask : t_skip_ops

    // issues on consecutive edges, strobe held high between them
    task automatic t_back_to_back;
        @(posedge sys_clk);
        issue_en <= 1'b1;
        op <= BIDL_OP_LOAD_LITERAL_ACCUM;
        dest_sel <= 1'b0;
        literal <= 8'h0f;
        @(posedge sys_clk);
        op <= BIDL_OP_OR_LITERAL_ACCUM;
        literal <= 8'hf0;
        #1;
        outs(8'h0f, 1'b1, 1'b0, 1'b0);
        @(posedge sys_clk);
        op <= BIDL_OP_DECREMENT_FILE;
        dest_sel <= 1'b1;
        file_addr <= 7'h15;
        file_rdata <= 8'h10;
        #1;
        outs(8'hff, 1'b0, 1'b0, 1'b0);
        @(posedge sys_clk);
        issue_en <= 1'b0;
        op <= BIDL_OP_NONE;
        file_addr <= 7'h2a;
        #1;
        outs(8'hff, 1'b0, 1'b1, 1'b0);
        chk({file_waddr, file_wdata}, {7'h15, 8'h0f});
    endtask : t_back_to_back

    // reset in mid-run while a skip write is in flight, then resume
    task automatic t_reset_mid;
        run(BIDL_OP_LOAD_LITERAL_ACCUM, 1'b0, 8'h5a, 8'h00);
        outs(8'h5a, 1'b0, 1'b0, 1'b0);
        @(posedge sys_clk);
        issue_en <= 1'b1;
        op <= BIDL_OP_INCREMENT_SKIP_ZERO;
        dest_sel <= 1'b1;
        file_rdata <= 8'hff;
        @(posedge sys_clk);
        issue_en <= 1'b0;
        op <= BIDL_OP_NONE;
        nrst <= 1'b0;
        #1;
        chk({accum, zero_flag, file_we, skip_next, file_waddr, file_wdata}, 32'h0);
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        #1;
        chk({accum, zero_flag, file_we, skip_next}, 11'h000);
        @(posedge sys_clk);
        #1;
        chk({accum, zero_flag, file_we, skip_next}, 11'h000);
        run(BIDL_OP_INCREMENT_SKIP_ZERO, 1'b1, 8'h00, 8'hff);
        outs(8'h00, 1'b0, 1'b1, 1'b1);
        chk({file_waddr, file_wdata}, {7'h2a, 8'h00});
    endtask : t_reset_mid

    task automatic print_verdict;
        if (bad_count == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict

    initial
    begin
        nrst = 1'b0;
        issue_en = 1'b0;
        op = BIDL_OP_NONE;
        dest_sel = 1'b0;
        file_addr = 7'h2a;
        literal = 8'h00;
        file_rdata = 8'h00;
        repeat (16) @(posedge sys_clk);
        #1;
        chk({accum, zero_flag, file_we, skip_next, file_waddr, file_wdata}, 32'h0);
        @(posedge sys_clk);
        nrst <= 1'b1;
        t_literal_ops();
        t_inc_dec();
        t_skip_ops();
        t_back_to_back();
        t_reset_mid();
        print_verdict();
    end
endmodule : tb_top

/* File: verilog/bidl_alu.sv */
/*
 * Combinational result unit: computes the 8-bit result and its zero test.
 * Assumes operands are stable for the cycle in which they are used.
 */
`timescale 1ns/10ps
`include "bidl_consts.svh"
module bidl_alu
    import bidl_pkg::*;
(
    // operation and operands
    input wire bidl_op_type op,
    input wire logic [`BIDL_DATA_W-1:0] file_val,
    input wire logic [`BIDL_DATA_W-1:0] acc_val,
    input wire logic [`BIDL_DATA_W-1:0] literal,
    // result
    output logic [`BIDL_DATA_W-1:0] result,
    output logic result_zero
);
    always_comb
    begin
        case (op)
            // 8-bit arithmetic drops the carry, so values wrap
            BIDL_OP_DECREMENT_FILE, BIDL_OP_DECREMENT_SKIP_ZERO:
                result = file_val - 8'h01; // see RQ2 see RQ4 see RQ10
            BIDL_OP_INCREMENT_FILE, BIDL_OP_INCREMENT_SKIP_ZERO:
                result = file_val + 8'h01; // see RQ3 see RQ5 see RQ10
            BIDL_OP_OR_LITERAL_ACCUM:
                result = acc_val | literal; // see RQ7
            BIDL_OP_LOAD_LITERAL_ACCUM:
                result = literal; // see RQ8
            default:
                result = acc_val;
        endcase
        result_zero = (result == 8'h00); // see RQ11
    end
endmodule : bidl_alu

/* File: verilog/bidl_consts.svh */
/*
 * Constants for the byte increment/decrement and literal datapath.
 * Assumes the core supplies one issue strobe per instruction cycle.
 */
// What this block does
// RQ1: d=0 result to accumulator, d=1 to file
// RQ2: decrement file, route result, update zero
// RQ3: increment file, route result, update zero
// RQ4: decrement-skip: no flags, skip when zero
// RQ5: increment-skip: no flags, skip when zero
// RQ6: nonzero skip result runs next normally
// RQ7: OR literal into accumulator, update zero
// RQ8: load literal into accumulator, flags kept
// RQ9: literal-load don't-care bits assembled as zero
// RQ10: increment and decrement wrap modulo 256
// RQ11: zero set iff result zero, any destination
`ifndef BIDL_CONSTS_SVH
`define BIDL_CONSTS_SVH
`define BIDL_DATA_W 8
`define BIDL_ADDR_W 7
`define BIDL_ACC_RST 8'h00
`define BIDL_ZERO_RST 1'b0
`define BIDL_DEST_ACC 1'b0
`define BIDL_DEST_FILE 1'b1
`endif

/* File: verilog/bidl_core.sv */
/*
 * Execution datapath for decrement/increment of a file register, their
 * skip-if-zero forms, literal OR and literal load into the accumulator.
 * Assumes the core issues at most one operation per issue_en pulse, reads
 * the file register value combinationally, and honours skip_next by
 * executing a no_operation in place of the following instruction.
 */
`timescale 1ns/10ps
`include "bidl_consts.svh"
module bidl_core
    import bidl_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // instruction issue
    input wire logic issue_en,
    input wire bidl_op_type op,
    input wire logic dest_sel,
    input wire logic [`BIDL_ADDR_W-1:0] file_addr,
    input wire logic [`BIDL_DATA_W-1:0] literal,
    // file register read data for file_addr
    input wire logic [`BIDL_DATA_W-1:0] file_rdata,
    // file register write back
    output logic file_we,
    output logic [`BIDL_ADDR_W-1:0] file_waddr,
    output logic [`BIDL_DATA_W-1:0] file_wdata,
    // architectural state
    output logic [`BIDL_DATA_W-1:0] accum,
    output logic zero_flag,
    // skip request: the next instruction cycle is a no_operation
    output logic skip_next
);
    typedef struct packed {
        logic [`BIDL_DATA_W-1:0] acc;
        logic zero;
        logic fwe;
        logic [`BIDL_ADDR_W-1:0] faddr;
        logic [`BIDL_DATA_W-1:0] fdata;
        logic skip;
    } bidl_state_type;

    bidl_state_type st_r;
    bidl_state_type st_nxt;
    logic [`BIDL_DATA_W-1:0] result;
    logic result_zero;

    function automatic logic is_file_op(input bidl_op_type o);
        is_file_op = (o == BIDL_OP_DECREMENT_FILE) || (o == BIDL_OP_INCREMENT_FILE)
            || (o == BIDL_OP_DECREMENT_SKIP_ZERO) || (o == BIDL_OP_INCREMENT_SKIP_ZERO);
    endfunction : is_file_op

    function automatic logic is_skip_op(input bidl_op_type o);
        is_skip_op = (o == BIDL_OP_DECREMENT_SKIP_ZERO)
            || (o == BIDL_OP_INCREMENT_SKIP_ZERO);
    endfunction : is_skip_op

    bidl_alu u_alu (
        .op(op),
        .file_val(file_rdata),
        .acc_val(st_r.acc),
        .literal(literal),
        .result(result),
        .result_zero(result_zero)
    );

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.fwe = 1'b0;
        st_nxt.skip = 1'b0;
        if (issue_en)
        begin
            if (is_file_op(op))
            begin
                if (dest_sel == `BIDL_DEST_FILE) // see RQ1
                begin
                    st_nxt.fwe = 1'b1;
                    st_nxt.faddr = file_addr;
                    st_nxt.fdata = result;
                end
                else
                begin
                    st_nxt.acc = result;
                end
                if (is_skip_op(op))
                begin
                    // skip ops leave flags alone; nonzero runs next normally
                    st_nxt.skip = result_zero; // see RQ4 see RQ5 see RQ6
                end
                else
                begin
                    st_nxt.zero = result_zero; // see RQ2 see RQ3 see RQ11
                end
            end
            else if (op == BIDL_OP_OR_LITERAL_ACCUM)
            begin
                st_nxt.acc = result;
                st_nxt.zero = result_zero; // see RQ7
            end
            else if (op == BIDL_OP_LOAD_LITERAL_ACCUM)
            begin
                // full literal is taken; don't-care bits are expected zero
                st_nxt.acc = result; // see RQ8
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_r <= '{acc: `BIDL_ACC_RST, zero: `BIDL_ZERO_RST, fwe: 1'b0,
                faddr: '0, fdata: '0, skip: 1'b0};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign file_we = st_r.fwe;
    assign file_waddr = st_r.faddr;
    assign file_wdata = st_r.fdata;
    assign accum = st_r.acc;
    assign zero_flag = st_r.zero;
    assign skip_next = st_r.skip;

    a_file_route: assert property (@(posedge sys_clk) disable iff (!nrst) // see RQ1
        (issue_en && is_file_op(op) && dest_sel) |=> file_we && file_wdata == $past(result))
        else $error("file op with dest file did not write back");
    a_acc_route: assert property (@(posedge sys_clk) disable iff (!nrst) // see RQ1
        (issue_en && is_file_op(op) && !dest_sel) |=> !file_we && accum == $past(result))
        else $error("file op with dest accumulator misrouted");
    a_dec_value: assert property (@(posedge sys_clk) disable iff (!nrst) // see RQ2
        (issue_en && op == BIDL_OP_DECREMENT_FILE && !dest_sel)
        |=> accum == 8'($past(file_rdata) - 8'h01) && zero_flag == (accum == 8'h00))
        else $error("decrement result or zero wrong");
    a_inc_value: assert property (@(posedge sys_clk) disable iff (!nrst) // see RQ3
        (issue_en && op == BIDL_OP_INCREMENT_FILE && dest_sel)
        |=> file_wdata == 8'($past(file_rdata) + 8'h01) && zero_flag == (file_wdata == 8'h00))
        else $error("increment result or zero wrong");
    a_skip_flags: assert property (@(posedge sys_clk) disable iff (!nrst) // see RQ4
        (issue_en && is_skip_op(op)) |=> $stable(zero_flag))
        else $error("skip op changed the zero flag");
    a_skip_zero: assert property (@(posedge sys_clk) disable iff (!nrst) // see RQ5
        (issue_en && is_skip_op(op) && result_zero) |=> skip_next ##1 !skip_next)
        else $error("zero skip result did not skip exactly once");
    a_no_skip: assert property (@(posedge sys_clk) disable iff (!nrst) // see RQ6
        (issue_en && is_skip_op(op) && !result_zero) |=> !skip_next)
        else $error("nonzero skip result inserted a skip");
    a_or_literal: assert property (@(posedge sys_clk) disable iff (!nrst) // see RQ7
        (issue_en && op == BIDL_OP_OR_LITERAL_ACCUM)
        |=> accum == ($past(accum) | $past(literal)) && zero_flag == (accum == 8'h00))
        else $error("literal or wrong");
    a_load_literal: assert property (@(posedge sys_clk) disable iff (!nrst) // see RQ8
        (issue_en && op == BIDL_OP_LOAD_LITERAL_ACCUM)
        |=> accum == $past(literal) && $stable(zero_flag))
        else $error("literal load wrong or flag changed");
    a_inc_wrap: assert property (@(posedge sys_clk) disable iff (!nrst) // see RQ10
        (issue_en && op == BIDL_OP_INCREMENT_SKIP_ZERO && file_rdata == 8'hff)
        |=> skip_next)
        else $error("increment of ff did not wrap to zero");

    // expectations below are rebuilt from the inputs, not from the result unit

    // a file destination must leave the accumulator alone
    a_file_addr: assert property (@(posedge sys_clk) disable iff (!nrst) // see RQ1
        (issue_en && is_file_op(op) && dest_sel)
        |=> file_waddr == $past(file_addr) && $stable(accum))
        else $error("file write address wrong or accumulator disturbed");

    // only a file-destination op may raise the write strobe
    a_write_only_file: assert property (@(posedge sys_clk) disable iff (!nrst) // see RQ1
        !(issue_en && is_file_op(op) && dest_sel) |=> !file_we)
        else $error("write strobe without a file destination op");

    a_dec_file: assert property (@(posedge sys_clk) disable iff (!nrst) // see RQ2
        (issue_en && op == BIDL_OP_DECREMENT_FILE && dest_sel)
        |=> file_wdata == 8'($past(file_rdata) - 8'h01)
            && zero_flag == (file_wdata == 8'h00))
        else $error("decrement to file wrong or zero wrong");

    a_inc_acc: assert property (@(posedge sys_clk) disable iff (!nrst) // see RQ3
        (issue_en && op == BIDL_OP_INCREMENT_FILE && !dest_sel)
        |=> accum == 8'($past(file_rdata) + 8'h01) && zero_flag == (accum == 8'h00))
        else $error("increment to accumulator wrong or zero wrong");

    a_dec_skip_zero: assert property (@(posedge sys_clk) disable iff (!nrst) // see RQ4
        (issue_en && op == BIDL_OP_DECREMENT_SKIP_ZERO && file_rdata == 8'h01)
        |=> skip_next)
        else $error("decrement of one did not request a skip");

    a_skip_value: assert property (@(posedge sys_clk) disable iff (!nrst) // see RQ4
        (issue_en && op == BIDL_OP_DECREMENT_SKIP_ZERO && dest_sel)
        |=> file_we && file_wdata == 8'($past(file_rdata) - 8'h01))
        else $error("decrement-skip stored the wrong value");

    a_inc_skip_value: assert property (@(posedge sys_clk) disable iff (!nrst) // see RQ5
        (issue_en && op == BIDL_OP_INCREMENT_SKIP_ZERO && !dest_sel)
        |=> accum == 8'($past(file_rdata) + 8'h01) && !file_we)
        else $error("increment-skip stored the wrong value");

    // a skip request comes only from a skip op
    a_skip_source: assert property (@(posedge sys_clk) disable iff (!nrst) // see RQ6
        !(issue_en && is_skip_op(op)) |=> !skip_next)
        else $error("skip requested by a non-skip op");

    a_or_no_write: assert property (@(posedge sys_clk) disable iff (!nrst) // see RQ7
        (issue_en && op == BIDL_OP_OR_LITERAL_ACCUM) |=> !file_we && !skip_next)
        else $error("literal or touched the file or the skip");

    a_load_no_write: assert property (@(posedge sys_clk) disable iff (!nrst) // see RQ8
        (issue_en && op == BIDL_OP_LOAD_LITERAL_ACCUM) |=> !file_we && !skip_next)
        else $error("literal load touched the file or the skip");

    a_dec_wrap: assert property (@(posedge sys_clk) disable iff (!nrst) // see RQ10
        (issue_en && op == BIDL_OP_DECREMENT_FILE && !dest_sel && file_rdata == 8'h00)
        |=> accum == 8'hff)
        else $error("decrement of zero did not wrap");

    // zero follows the result whichever way it was routed
    a_zero_any_dest: assert property (@(posedge sys_clk) disable iff (!nrst) // see RQ11
        (issue_en && (op == BIDL_OP_DECREMENT_FILE || op == BIDL_OP_INCREMENT_FILE))
        |=> zero_flag == (($past(op) == BIDL_OP_DECREMENT_FILE)
            ? ($past(file_rdata) == 8'h01) : ($past(file_rdata) == 8'hff)))
        else $error("zero flag does not follow the result");
endmodule : bidl_core

/* File: verilog/bidl_pkg.sv */
/*
 * Types for the byte increment/decrement and literal datapath.
 * Assumes nothing of its surroundings.
 */
package bidl_pkg;
    typedef enum logic [2:0] {
        BIDL_OP_NONE,
        BIDL_OP_DECREMENT_FILE,
        BIDL_OP_INCREMENT_FILE,
        BIDL_OP_DECREMENT_SKIP_ZERO,
        BIDL_OP_INCREMENT_SKIP_ZERO,
        BIDL_OP_OR_LITERAL_ACCUM,
        BIDL_OP_LOAD_LITERAL_ACCUM
    } bidl_op_type;
endpackage : bidl_pkg
